/* File: src/msix_capability_regs.sv */
// extended message capability registers, vector table and request gating
// assumes single-cycle config and table ports on clk, sources on clk
`timescale 1ns/1ps
module msix_capability_regs (
  input wire logic clk, // core clock, 125 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] next_ptr, // next capability pointer
  input wire msix_cap_pkg::cfg_req_t cfg_req, // config access to capability
  output logic [31:0] cfg_rdata, // config read data
  input wire msix_cap_pkg::cfg_req_t tbl_req, // memory access to vector table
  output logic [31:0] tbl_rdata, // table read data
  input wire logic msi_enable, // plain msi enable from msi capability
  input wire logic [1:0] vec_req, // per-vector service request
  output logic [1:0] vec_fire, // pulse: vector message to send
  output logic [1:0] vec_masked, // per-vector effective mask
  output msix_cap_pkg::vec_entry_t vec0_entry, // entry 0 contents
  output msix_cap_pkg::vec_entry_t vec1_entry, // entry 1 contents
  output logic msix_active, // vector mode in use
  output logic intx_allow // legacy interrupt permitted
);

  logic enable_r;
  logic enable_nxt;
  logic fmask_r;
  logic fmask_nxt;
  logic [31:0] cfg_rdata_r;
  logic [31:0] cfg_rdata_nxt;
  logic [31:0] tbl_rdata_r;
  logic [31:0] tbl_rdata_nxt;
  logic [1:0] fire_r;
  logic [1:0] fire_nxt;
  logic [1:0] masked_r;
  logic [1:0] masked_nxt;
  logic active_r;
  logic active_nxt;
  logic intx_r;
  logic intx_nxt;
  msix_cap_pkg::vec_entry_t ent_r [msix_cap_pkg::num_vectors];
  msix_cap_pkg::vec_entry_t ent_nxt [msix_cap_pkg::num_vectors];
  logic [15:0] ctl_word;
  logic [31:0] loc_word;
  logic [31:0] pba_word;
  logic tbl_sel;
  logic [1:0] tbl_dw;

  // capability words
  always_comb begin
    ctl_word = {enable_r, fmask_r, msix_cap_pkg::ctl_rsvd_val,
                msix_cap_pkg::table_size_val};
    loc_word = {msix_cap_pkg::table_offset_val,
                msix_cap_pkg::table_bar_sel_val};
    pba_word = {msix_cap_pkg::pba_offset_val, msix_cap_pkg::pba_bar_sel_val};
  end

  // control bits and config reads
  always_comb begin
    enable_nxt = enable_r;
    fmask_nxt = fmask_r;
    cfg_rdata_nxt = cfg_rdata_r;
    if (cfg_req.wr && cfg_req.addr == msix_cap_pkg::cap_off_hdr) begin
      enable_nxt = cfg_req.wdata[msix_cap_pkg::ctl_lsb + msix_cap_pkg::ctl_enable_bit];
      fmask_nxt = cfg_req.wdata[msix_cap_pkg::ctl_lsb + msix_cap_pkg::ctl_fmask_bit];
    end
    if (cfg_req.rd) begin
      if (cfg_req.addr == msix_cap_pkg::cap_off_hdr) begin
        cfg_rdata_nxt = {ctl_word, next_ptr, msix_cap_pkg::cap_id_val};
      end else if (cfg_req.addr == msix_cap_pkg::cap_off_table) begin
        cfg_rdata_nxt = loc_word;
      end else if (cfg_req.addr == msix_cap_pkg::cap_off_pba) begin
        cfg_rdata_nxt = pba_word;
      end else begin
        cfg_rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_r <= msix_cap_pkg::ctl_enable_rst;
      fmask_r <= msix_cap_pkg::ctl_fmask_rst;
      cfg_rdata_r <= 32'h00000000;
    end else begin
      enable_r <= enable_nxt;
      fmask_r <= fmask_nxt;
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  // vector table: entry index from address bit 4, dword from bits 3:2
  always_comb begin
    tbl_sel = tbl_req.addr[4];
    tbl_dw = tbl_req.addr[3:2];
  end

  always_comb begin
    for (int i = 0; i < msix_cap_pkg::num_vectors; i++) begin
      ent_nxt[i] = ent_r[i];
    end
    tbl_rdata_nxt = tbl_rdata_r;
    if (tbl_req.wr && tbl_req.addr[7:5] == 3'h0) begin
      if (tbl_dw == msix_cap_pkg::dw_msg_addr) begin
        ent_nxt[tbl_sel].addr = {tbl_req.wdata[31:2], 2'h0};
      end else if (tbl_dw == msix_cap_pkg::dw_msg_upper) begin
        ent_nxt[tbl_sel].upper = tbl_req.wdata;
      end else if (tbl_dw == msix_cap_pkg::dw_msg_data) begin
        ent_nxt[tbl_sel].data = tbl_req.wdata;
      end else begin
        ent_nxt[tbl_sel].ctrl = {31'h00000000, tbl_req.wdata[0]};
      end
    end
    if (tbl_req.rd) begin
      if (tbl_req.addr[7:5] != 3'h0) begin
        tbl_rdata_nxt = 32'h00000000;
      end else if (tbl_dw == msix_cap_pkg::dw_msg_addr) begin
        tbl_rdata_nxt = ent_r[tbl_sel].addr;
      end else if (tbl_dw == msix_cap_pkg::dw_msg_upper) begin
        tbl_rdata_nxt = ent_r[tbl_sel].upper;
      end else if (tbl_dw == msix_cap_pkg::dw_msg_data) begin
        tbl_rdata_nxt = ent_r[tbl_sel].data;
      end else begin
        tbl_rdata_nxt = ent_r[tbl_sel].ctrl;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < msix_cap_pkg::num_vectors; i++) begin
        ent_r[i] <= '{addr: 32'h00000000, upper: 32'h00000000, data: 32'h00000000,
                      ctrl: msix_cap_pkg::entry_mask_rst};
      end
      tbl_rdata_r <= 32'h00000000;
    end else begin
      for (int i = 0; i < msix_cap_pkg::num_vectors; i++) begin
        ent_r[i] <= ent_nxt[i];
      end
      tbl_rdata_r <= tbl_rdata_nxt;
    end
  end

  // per-vector masking and message gating
  always_comb begin
    for (int i = 0; i < msix_cap_pkg::num_vectors; i++) begin
      masked_nxt[i] = fmask_nxt | ent_nxt[i].ctrl[0];
    end
    active_nxt = enable_nxt & ~msi_enable;
    intx_nxt = ~enable_nxt & ~msi_enable;
    fire_nxt = vec_req & ~masked_nxt & {2{active_nxt}};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      masked_r <= 2'h3;
      active_r <= 1'b0;
      intx_r <= 1'b1;
      fire_r <= 2'h0;
    end else begin
      masked_r <= masked_nxt;
      active_r <= active_nxt;
      intx_r <= intx_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign cfg_rdata = cfg_rdata_r;
  assign tbl_rdata = tbl_rdata_r;
  assign vec_fire = fire_r;
  assign vec_masked = masked_r;
  assign vec0_entry = ent_r[0];
  assign vec1_entry = ent_r[1];
  assign msix_active = active_r;
  assign intx_allow = intx_r;

endmodule : msix_capability_regs

/* File: src/msix_cap_pkg.sv */
// constants and carrier types for the extended message capability block
// assumes a dword-wide configuration access port on the core clock
package msix_cap_pkg;

  // capability layout, dword byte offsets from the capability pointer
  localparam logic [7:0] cap_off_hdr = 8'h00;
  localparam logic [7:0] cap_off_table = 8'h04;
  localparam logic [7:0] cap_off_pba = 8'h08;

  // header fields
  localparam logic [7:0] cap_id_val = 8'h11;
  localparam int ctl_lsb = 16;
  localparam int ctl_enable_bit = 15;
  localparam int ctl_fmask_bit = 14;
  localparam logic [10:0] table_size_val = 11'h001;
  localparam logic [2:0] ctl_rsvd_val = 3'h0;
  localparam logic ctl_enable_rst = 1'b0;
  localparam logic ctl_fmask_rst = 1'b0;

  // table location: offset field bits 31:3, indicator bits 2:0
  localparam logic [28:0] table_offset_val = 29'h0000000;
  localparam logic [2:0] table_bar_sel_val = 3'h0;
  localparam logic [28:0] pba_offset_val = 29'h0000100;
  localparam logic [2:0] pba_bar_sel_val = 3'h0;
  localparam logic [2:0] bar_sel_max = 3'h2;

  // vector table
  localparam int num_vectors = 2;
  localparam logic [7:0] entry_bytes = 8'h10;
  localparam logic [1:0] dw_msg_addr = 2'h0;
  localparam logic [1:0] dw_msg_upper = 2'h1;
  localparam logic [1:0] dw_msg_data = 2'h2;
  localparam logic [1:0] dw_vec_ctrl = 2'h3;
  localparam logic [31:0] entry_mask_rst = 32'h00000001;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] upper;
    logic [31:0] data;
    logic [31:0] ctrl;
  } vec_entry_t;

endpackage : msix_cap_pkg

/* File: testbench/msix_cap_monitor.sv */
// port assertions for the capability block
// bound into every msix_capability_regs instance
`timescale 1ns/1ps
module msix_cap_monitor (
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic [7:0] next_ptr, // pointer
  input wire msix_cap_pkg::cfg_req_t cfg_req, // config req
  input wire logic [31:0] cfg_rdata, // config data
  input wire msix_cap_pkg::cfg_req_t tbl_req, // table req
  input wire logic [31:0] tbl_rdata, // table data
  input wire logic msi_enable, // msi on
  input wire logic [1:0] vec_req, // requests
  input wire logic [1:0] vec_fire, // fires
  input wire logic [1:0] vec_masked, // masks
  input wire msix_cap_pkg::vec_entry_t vec0_entry, // entry 0
  input wire msix_cap_pkg::vec_entry_t vec1_entry, // entry 1
  input wire logic msix_active, // vector mode
  input wire logic intx_allow // legacy ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_hdr_rd; cfg_req.rd && cfg_req.addr == 8'h00; endsequence
  sequence s_loc_rd; cfg_req.rd && cfg_req.addr == 8'h04; endsequence
  property p_hdr; s_hdr_rd |=> cfg_rdata[29:0] == {14'h0001, $past(next_ptr), 8'h11}; endproperty
  a_hdr: assert property (p_hdr) else $error("header read wrong");
  property p_loc; s_loc_rd |=> cfg_rdata == 32'h00000000; endproperty
  a_loc: assert property (p_loc) else $error("location read wrong");
  property p_ent; tbl_req.rd && tbl_req.addr == 8'h18 |=> tbl_rdata == $past(vec1_entry.data); endproperty
  a_ent: assert property (p_ent) else $error("entry read wrong");
  property p_gate; vec_fire[0] |-> msix_active && !vec_masked[0]; endproperty
  a_gate: assert property (p_gate) else $error("fire while gated");
  property p_fire; $past(vec_req[1]) && msix_active && !vec_masked[1] |-> vec_fire[1]; endproperty
  a_fire: assert property (p_fire) else $error("fire missing");
  property p_own; vec0_entry.ctrl[0] |-> vec_masked[0]; endproperty
  a_own: assert property (p_own) else $error("own mask ignored");
  property p_excl; !(msix_active && intx_allow); endproperty
  a_excl: assert property (p_excl) else $error("both modes on");
  property p_msi; msi_enable |=> !msix_active && !intx_allow; endproperty
  a_msi: assert property (p_msi) else $error("msi not exclusive");
  property p_keep; cfg_req.wr && !tbl_req.wr |=> vec0_entry.ctrl == $past(vec0_entry.ctrl); endproperty
  a_keep: assert property (p_keep) else $error("entry mask disturbed");
endmodule : msix_cap_monitor
bind msix_capability_regs msix_cap_monitor msix_cap_monitor_inst (.*);

/* File: testbench/msix_host_model.sv */
// host model: config software and table driver
// drives both access ports at the falling edge
`timescale 1ns/1ps
module msix_host_model (
  input wire logic clk, // core clock
  input wire logic [31:0] cfg_rdata, // config data
  input wire logic [31:0] tbl_rdata, // table data
  output msix_cap_pkg::cfg_req_t cfg_req, // config req
  output msix_cap_pkg::cfg_req_t tbl_req, // table req
  output logic msi_enable // plain msi on
);
  initial begin
    cfg_req = '0;
    tbl_req = '0;
    msi_enable = 1'b0;
  end
  task automatic set_msi(input logic v);
    @(negedge clk);
    msi_enable = v;
  endtask : set_msi
  task automatic access(input logic t, input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    msix_cap_pkg::cfg_req_t r;
    r = {w, !w, a, d};
    if (t && a[3:2] == 2'h0) r.wdata[1:0] = 2'h0;
    @(negedge clk);
    if (t) tbl_req = r;
    else cfg_req = r;
    @(negedge clk);
    q = t ? tbl_rdata : cfg_rdata;
    cfg_req = '0;
    tbl_req = '0;
  endtask : access
endmodule : msix_host_model

/* File: testbench/msix_capability_regs_tb.sv */
// bench for the capability block
// host model drives both access ports
`timescale 1ns/1ps
module msix_capability_regs_tb;
  logic clk = 1'b0, nrst = 1'b0;
  logic [7:0] next_ptr = 8'h5a;
  logic [1:0] vec_req = 2'h0, vec_fire, vec_masked;
  logic [31:0] q, p, cfg_rdata, tbl_rdata;
  logic msi_enable, msix_active, intx_allow;
  int num_errors = 0, checks = 0;
  msix_cap_pkg::cfg_req_t cfg_req, tbl_req;
  msix_cap_pkg::vec_entry_t vec0_entry, vec1_entry;
  always #4 clk = ~clk;
  msix_capability_regs msix_capability_regs_inst (.*);
  msix_host_model msix_host_model_inst (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic go(input logic t, input logic w, input logic [7:0] a, input logic [31:0] d);
    msix_host_model_inst.access(t, w, a, d, q);
  endtask : go
  task automatic pulse(input logic [1:0] r, input logic [1:0] e);
    @(negedge clk);
    vec_req = r;
    @(negedge clk);
    vec_req = 2'h0;
    chk({30'h0, vec_fire}, {30'h0, e});
  endtask : pulse
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    go(0, 0, 8'h00, 0);
    chk(q, 32'h00015a11);
    go(0, 1, 8'h00, 32'hffffffff);
    go(0, 0, 8'h00, 0);
    chk(q, 32'hc0015a11);
    go(0, 1, 8'h04, 32'hffffffff);
    go(0, 0, 8'h04, 0);
    chk(q, 32'h00000000);
    go(0, 0, 8'h08, 0);
    chk(q, {msix_cap_pkg::pba_offset_val, msix_cap_pkg::pba_bar_sel_val});
    go(0, 0, 8'h0c, 0);
    chk(q, 32'h00000000);
    $display("test config done");
    for (int i = 0; i < 8; i++) begin
      p = {i[3:0], 28'h5a5a5a4};
      go(1, 1, 8'(i * 4), p);
      go(1, 0, 8'(i * 4), 0);
      chk(q, (i % 4 == 3) ? (p & 32'h1) : p);
    end
    chk(vec1_entry.data, 32'h65a5a5a4);
    go(1, 1, 8'h20, 32'hffffffff);
    go(1, 0, 8'h20, 0);
    chk(q, 32'h00000000);
    chk(vec0_entry.addr, 32'h05a5a5a4);
    $display("test table done");
    pulse(2'h3, 2'h0);
    go(0, 1, 8'h00, 32'h80000000);
    pulse(2'h3, 2'h3);
    chk({30'h0, intx_allow, msix_active}, 32'h1);
    chk(vec0_entry.ctrl, 32'h0);
    go(1, 1, 8'h1c, 32'h1);
    pulse(2'h3, 2'h1);
    msix_host_model_inst.set_msi(1'b1);
    pulse(2'h3, 2'h0);
    chk({30'h0, intx_allow, msix_active}, 32'h0);
    msix_host_model_inst.set_msi(1'b0);
    go(0, 1, 8'h00, 32'h0);
    pulse(2'h3, 2'h0);
    chk({30'h0, intx_allow, msix_active}, 32'h2);
    $display("test gating done");
    give_verdict();
  end
endmodule : msix_capability_regs_tb
